// File: hw/sfr_map.svh
// Purpose: Offsets, field positions, masks and timing figures for the fault response block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
`define SFR_CFG_ADDR 8'hD9
`define SFR_CFG_RESET 32'h0000_0000
`define SFR_CFG_WMASK 32'h0707_F7FF
`define SFR_FOLLOW_LSB 24
`define SFR_DRIVE_LSB 16
`define SFR_NVLOG_BIT 15
`define SFR_GLOBAL_BIT 14
`define SFR_FILT_LSB 12
`define SFR_ALARM_LSB 8
`define SFR_OT_LSB 6
`define SFR_TON_LSB 4
`define SFR_UV_LSB 2
`define SFR_OVC_LSB 0
`define SFR_SEL_SEQ 6'h10
`define SFR_SEL_VMON 6'h20
`define SFR_SEL_IMON 6'h22
`define SFR_FIRST_FIXED_GLOBAL 12
`define SFR_CLK_PERIOD_NS 25
`define SFR_TICK_US 1000
`define SFR_FILT_EXTRA 3'h2
`endif

// File: hw/sfr_pkg.sv
// Purpose: Shared types of the fault response block
// Assumes: Nothing
// Notes: Used by scope, never imported
package sfr_pkg;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_LATCH = 2'b01,
    ACT_RETRY = 2'b10,
    ACT_CONTINUE = 2'b11
  } action_t;
  typedef enum logic [1:0] {
    SUP_OFF = 2'b00,
    SUP_ON = 2'b01,
    SUP_DRAIN = 2'b10
  } supply_state_t;
  // Fault type index, also the log and status bit order
  typedef enum logic [2:0] {
    FT_OV = 3'h0,
    FT_OC = 3'h1,
    FT_UV = 3'h2,
    FT_SEQ = 3'h3,
    FT_OT = 3'h4
  } fault_type_t;
endpackage

// File: hw/excursion_filter.sv
// Purpose: Persistence filter for one limit excursion
// Assumes: tick_i is a one-cycle pulse every millisecond
// Notes: Partial first tick is counted, so one extra tick keeps a window from being short
`timescale 1ns/1ps
`include "sfr_map.svh"
module excursion_filter (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic [1:0] sel_i,
  input wire logic raw_i,
  output logic fault_o
);
  logic [2:0] cnt_r;
  logic [2:0] need;

  // Code 01 needs 2 ms, so 3 ticks guarantee it whatever the phase
  assign need = 3'(sel_i) + `SFR_FILT_EXTRA;

  // Count ticks while the excursion lasts, restart on any gap
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 3'h0;
    end else if (!raw_i) begin
      cnt_r <= 3'h0;
    end else if (tick_i && cnt_r != need) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // Registered decision
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= raw_i && (sel_i == 2'b00 || cnt_r == need);
    end
  end
endmodule

// File: hw/supply_fault_response.sv
// Purpose: Per-channel fault response: filters, actions, shared fault pins, supply enable
// Assumes: Inputs synchronous to clk_i; shared pins are active-low open drain
// Notes: Delays are counted in millisecond ticks from an internal divider
`timescale 1ns/1ps
`include "sfr_map.svh"
// Operation
// - Global channel follows only shared pins whose follow bit is set.
// - Followed pin asserted drops supply enable, at once or after turn-off delay.
// - Supply stays off until followed pins release and channel is fault-free.
// - Temperature fault is the OR of all enabled sensor faults.
// - Global channels use worst global response; latch or retry drives all global pins.
// - Local channel applies its own overtemperature response.
// - Before enabling or releasing pins, check OV, OC, OT with latch or retry.
// - Power-up timeout fault when power-good not reached within the time limit.
// - Log faults when log enable set, except those with no-action response.
// - Log each fault type once until clear-faults or reset.
// - OV monitored in voltage modes, OC in current mode, continuously.
// - Undervoltage suspended while off, resumes above power-good-on level.
// - Power-up time monitored only on sequencing channels during power-on.
// - Overtemperature monitored for every enabled sensor.
// - Unused register bits read as zero.
// - Each shared pin has its own drive enable; only enabled pins assert.
// - Scope bit: zero local, one global.
// - Filter code sets persistence: immediate, 2, 3 or 4 ms.
// - No filter on temperature or sequencing faults.
// - Four two-bit response fields: OT, timeout, UV, OV or OC.
// - UV and timeout ignored on current channels; timeout ignored on 12 to 15.
// - Local codes: retry off-wait-restart, latch off, continue with log, status only.
// - Global codes: retry drives pins then releases, latch drives and holds.
// - OV/OC/UV alarm follows condition; sequencing alarm held until clear or power off.
// - Every fault latches status and alerts when alerting is enabled.
module supply_fault_response #(
  parameter int CHANNEL_ID = 0,
  parameter int TICK_CYCLES = `SFR_TICK_US * 1000 / `SFR_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic cmd_wr_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] cmd_rdata_o,
  input wire logic [5:0] channel_function_setup_i,
  input wire logic [4:0] temp_fault_i,
  input wire logic [4:0] temp_sensor_setup_i,
  input wire logic ov_excursion_i,
  input wire logic oc_excursion_i,
  input wire logic uv_excursion_i,
  input wire logic above_pgon_i,
  input wire logic power_good_i,
  input wire logic sequence_on_i,
  input wire logic power_off_i,
  input wire logic clear_faults_i,
  input wire logic alert_enable_i,
  input wire logic off_delay_select_i,
  input wire logic [15:0] turn_off_delay_i,
  input wire logic [15:0] retry_delay_setting_i,
  input wire logic [15:0] power_up_time_limit_i,
  input wire logic [1:0] global_ot_worst_i,
  input wire logic [2:0] global_drive_union_i,
  input wire logic [2:0] shared_fault_pin_n_i,
  output logic [2:0] shared_fault_pin_n_o,
  output logic [2:0] shared_fault_pin_oe_o,
  output logic supply_enable_out_o,
  output logic [4:0] status_o,
  output logic alert_o,
  output logic log_req_o,
  output logic [4:0] log_type_o,
  output logic alarm_o
);
  logic [31:0] cfg_r;
  logic [15:0] div_r;
  logic tick;
  sfr_pkg::supply_state_t sup_r;
  logic [15:0] drain_r, retry_r, ton_r;
  logic latch_r, retrying_r, uv_armed_r, pg_seen_r, seq_alarm_r;
  logic [4:0] flt_prev_r, logged_r;
  logic [4:0] flt, ev, act_live, to_log;
  logic [2:0] follow_en, drive_en, followed;
  logic vmode, imode, smode, is_global, nonvolatile_log_enable;
  logic ov_raw, oc_raw, uv_raw, ton_raw, ot_raw;
  logic ov_f, oc_f, uv_f, pin_hold, prefault, local_stop, off_req, retry_done;
  sfr_pkg::action_t act_ovc, act_uv, act_ton, act_ot;
  logic [4:0] stop_latch, stop_retry;

  // Field views of the configuration word
  assign follow_en = cfg_r[`SFR_FOLLOW_LSB +: 3];
  assign drive_en = cfg_r[`SFR_DRIVE_LSB +: 3];
  assign nonvolatile_log_enable = cfg_r[`SFR_NVLOG_BIT];
  assign is_global = cfg_r[`SFR_GLOBAL_BIT];
  assign vmode = channel_function_setup_i == `SFR_SEL_SEQ || channel_function_setup_i == `SFR_SEL_VMON;
  assign imode = channel_function_setup_i == `SFR_SEL_IMON;
  assign smode = channel_function_setup_i == `SFR_SEL_SEQ;

  // Configuration register; reserved bits are never stored, so they read zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_r <= `SFR_CFG_RESET;
    end else if (cmd_wr_i && cmd_addr_i == `SFR_CFG_ADDR) begin
      cfg_r <= cmd_wdata_i & `SFR_CFG_WMASK;
    end
  end
  assign cmd_rdata_o = cfg_r;

  // Millisecond tick divider
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_r <= 16'h0000;
    end else if (tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = div_r == 16'(TICK_CYCLES - 1);

  // Response fields; ignored fields behave as status-only
  always_comb begin
    act_ovc = sfr_pkg::action_t'(cfg_r[`SFR_OVC_LSB +: 2]);
    act_uv = imode ? sfr_pkg::ACT_NONE : sfr_pkg::action_t'(cfg_r[`SFR_UV_LSB +: 2]);
    act_ton = (imode || CHANNEL_ID >= `SFR_FIRST_FIXED_GLOBAL) ? sfr_pkg::ACT_NONE
                : sfr_pkg::action_t'(cfg_r[`SFR_TON_LSB +: 2]);
    // Global channels share the worst global temperature response
    act_ot = is_global ? sfr_pkg::action_t'(global_ot_worst_i)
               : sfr_pkg::action_t'(cfg_r[`SFR_OT_LSB +: 2]);
  end
  assign act_live = {act_ot != sfr_pkg::ACT_NONE, act_ton != sfr_pkg::ACT_NONE, act_uv != sfr_pkg::ACT_NONE,
                     {2{act_ovc != sfr_pkg::ACT_NONE}}};

  // Raw conditions gated by the channel mode; temperature by the sensor setup only
  assign ov_raw = vmode && ov_excursion_i;
  assign oc_raw = imode && oc_excursion_i;
  assign uv_raw = vmode && uv_armed_r && uv_excursion_i;
  assign ot_raw = |(temp_fault_i & temp_sensor_setup_i);
  assign ton_raw = smode && sup_r == sfr_pkg::SUP_ON && !pg_seen_r
                   && ton_r >= power_up_time_limit_i;

  // One filter per limit; temperature and timeout bypass it
  excursion_filter u_ov_filt (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick),
    .sel_i(cfg_r[`SFR_FILT_LSB +: 2]), .raw_i(ov_raw), .fault_o(ov_f));
  excursion_filter u_oc_filt (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick),
    .sel_i(cfg_r[`SFR_FILT_LSB +: 2]), .raw_i(oc_raw), .fault_o(oc_f));
  excursion_filter u_uv_filt (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick),
    .sel_i(cfg_r[`SFR_FILT_LSB +: 2]), .raw_i(uv_raw), .fault_o(uv_f));
  assign flt = {ot_raw, ton_raw, uv_f, oc_f, ov_f};

  // Undervoltage arming and power-good tracking follow the supply
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_armed_r <= 1'b0;
      pg_seen_r <= 1'b0;
    end else if (sup_r == sfr_pkg::SUP_OFF) begin
      uv_armed_r <= 1'b0;
      pg_seen_r <= 1'b0;
    end else begin
      uv_armed_r <= uv_armed_r || above_pgon_i;
      pg_seen_r <= pg_seen_r || power_good_i;
    end
  end

  // Power-up time counter, live only during the power-on phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ton_r <= 16'h0000;
    end else if (sup_r != sfr_pkg::SUP_ON || pg_seen_r || !smode) begin
      ton_r <= 16'h0000;
    end else if (tick && ton_r != 16'hFFFF) begin
      ton_r <= ton_r + 16'h0001;
    end
  end

  // New faults are rising edges of the qualified conditions
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flt_prev_r <= 5'h00;
    end else begin
      flt_prev_r <= flt;
    end
  end
  assign ev = flt & ~flt_prev_r;

  // Status bits are sticky; a new fault wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_o <= 5'h00;
      alert_o <= 1'b0;
    end else begin
      status_o <= (clear_faults_i ? 5'h00 : status_o) | ev;
      alert_o <= alert_enable_i && |ev;
    end
  end

  // Fault log requests, one per type until cleared
  assign to_log = nonvolatile_log_enable ? (ev & act_live & ~logged_r) : 5'h00;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      logged_r <= 5'h00;
      log_req_o <= 1'b0;
      log_type_o <= 5'h00;
    end else begin
      logged_r <= (clear_faults_i ? 5'h00 : logged_r) | to_log;
      log_req_o <= |to_log;
      log_type_o <= to_log;
    end
  end

  // Which new faults ask for latch-off or retry
  always_comb begin
    stop_latch = {act_ot == sfr_pkg::ACT_LATCH, act_ton == sfr_pkg::ACT_LATCH,
                  act_uv == sfr_pkg::ACT_LATCH, {2{act_ovc == sfr_pkg::ACT_LATCH}}} & ev;
    stop_retry = {act_ot == sfr_pkg::ACT_RETRY, act_ton == sfr_pkg::ACT_RETRY,
                  act_uv == sfr_pkg::ACT_RETRY, {2{act_ovc == sfr_pkg::ACT_RETRY}}} & ev;
  end

  // Pre-enable check: present OV, OC or OT faults that stop the channel
  assign prefault = (ov_f || oc_f) && act_ovc inside {sfr_pkg::ACT_LATCH, sfr_pkg::ACT_RETRY}
                    || ot_raw && act_ot inside {sfr_pkg::ACT_LATCH, sfr_pkg::ACT_RETRY};

  // Latch-off holds until master power off; it outranks a pending retry
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_r <= 1'b0;
    end else if (|stop_latch) begin
      latch_r <= 1'b1;
    end else if (power_off_i) begin
      latch_r <= 1'b0;
    end
  end

  // Retry wait; release only when no OV, OC or OT fault that stops the channel is present
  assign retry_done = retry_r >= retry_delay_setting_i;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      retrying_r <= 1'b0;
      retry_r <= 16'h0000;
    end else if (|stop_retry) begin
      retrying_r <= 1'b1;
      retry_r <= 16'h0000;
    end else if (retrying_r && retry_done && !prefault) begin
      retrying_r <= 1'b0;
    end else if (retrying_r && tick && !retry_done) begin
      retry_r <= retry_r + 16'h0001;
    end
  end

  // Shared pins: global channels follow and drive, local ones do neither
  assign followed = is_global ? (follow_en & ~shared_fault_pin_n_i) : 3'h0;
  assign pin_hold = |followed;
  assign local_stop = !is_global && (latch_r || retrying_r);
  assign off_req = !sequence_on_i || pin_hold || local_stop;

  // Supply enable sequencing with optional turn-off delay
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sup_r <= sfr_pkg::SUP_OFF;
      drain_r <= 16'h0000;
    end else begin
      unique case (sup_r)
        sfr_pkg::SUP_OFF: begin
          drain_r <= 16'h0000;
          if (sequence_on_i && !pin_hold && !local_stop && !prefault) begin
            sup_r <= sfr_pkg::SUP_ON;
          end
        end
        sfr_pkg::SUP_ON: begin
          if (off_req) begin
            sup_r <= off_delay_select_i ? sfr_pkg::SUP_DRAIN : sfr_pkg::SUP_OFF;
          end
        end
        sfr_pkg::SUP_DRAIN: begin
          if (drain_r >= turn_off_delay_i) begin
            sup_r <= sfr_pkg::SUP_OFF;
          end else if (tick) begin
            drain_r <= drain_r + 16'h0001;
          end
        end
        default: begin
          sup_r <= sfr_pkg::SUP_OFF;
        end
      endcase
    end
  end
  assign supply_enable_out_o = sup_r != sfr_pkg::SUP_OFF;

  // Pin drive; temperature faults on a global channel add every global pin
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shared_fault_pin_oe_o <= 3'h0;
    end else if (is_global && (latch_r || retrying_r)) begin
      // Pins added by a temperature stop stay driven until that stop ends, not just while it lasts
      shared_fault_pin_oe_o <= drive_en
        | ((ot_raw ? 3'h7 : shared_fault_pin_oe_o) & global_drive_union_i);
    end else begin
      shared_fault_pin_oe_o <= 3'h0;
    end
  end
  assign shared_fault_pin_n_o = 3'h0;

  // Alarm: level alarms follow the condition, sequencing alarm is held
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_alarm_r <= 1'b0;
      alarm_o <= 1'b0;
    end else begin
      seq_alarm_r <= ton_raw || (seq_alarm_r && !clear_faults_i && !power_off_i);
      unique case (cfg_r[`SFR_ALARM_LSB +: 3])
        3'h1: alarm_o <= ton_raw || seq_alarm_r;
        3'h2, 3'h3: alarm_o <= uv_f;
        3'h4, 3'h5: alarm_o <= ov_f || oc_f;
        3'h6, 3'h7: alarm_o <= uv_f || ov_f || oc_f;
        3'h0: alarm_o <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_rsvd_read_zero: assert property (cmd_rdata_o[31:27] == 5'h00 && cmd_rdata_o[23:19] == 5'h00
    && !cmd_rdata_o[11]) else $error("reserved bit reads one");
  a_pin_drive_mask: assert property ((shared_fault_pin_oe_o & ~(drive_en | global_drive_union_i)) == 3'h0)
    else $error("pin driven without enable");
  a_local_no_drive: assert property (!is_global && !$past(is_global) |-> shared_fault_pin_oe_o == 3'h0)
    else $error("local channel drives pin");
  a_pin_drop_now: assert property (sup_r == sfr_pkg::SUP_ON && pin_hold && !off_delay_select_i
    |=> !supply_enable_out_o) else $error("supply kept on under followed pin");
  a_hold_until_free: assert property ($rose(supply_enable_out_o) |-> $past(!pin_hold && !prefault))
    else $error("supply enabled while blocked");
  a_uv_suspended: assert property (!supply_enable_out_o |-> ##1 !uv_raw)
    else $error("undervoltage checked while off");
  a_log_needs_enable: assert property (log_req_o |-> $past(nonvolatile_log_enable) && (log_type_o & ~logged_r) == 5'h00)
    else $error("log without enable or not recorded");
  a_latch_holds: assert property (latch_r && !power_off_i |=> latch_r)
    else $error("latch-off released early");
  a_status_sticky: assert property (status_o[0] && !clear_faults_i |=> status_o[0])
    else $error("status bit lost");
  a_seq_alarm_hold: assert property (seq_alarm_r && !clear_faults_i && !power_off_i |=> seq_alarm_r)
    else $error("sequencing alarm dropped");

  c_retry_release: cover property (retrying_r ##1 !retrying_r);
  c_pin_follow: cover property (pin_hold && supply_enable_out_o);
  c_log_write: cover property (log_req_o);
  c_ton_fault: cover property ($rose(ton_raw));
endmodule

// File: tb/supply_peer_model.sv
// Purpose: Far side of one channel: a supply with power-good and peers on the shared pins
// Assumes: Shared pins are active-low open drain with pull-ups
// Notes: A hung supply never reaches power-good, so timeout paths can be reached
`timescale 1ns/1ps
module supply_peer_model #(
  parameter int PG_CYCLES = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic supply_enable_i,
  input wire logic hang_i,
  input wire logic [2:0] dut_oe_i,
  input wire logic [2:0] peer_pull_i,
  output logic [2:0] pin_n_o,
  output logic power_good_o
);
  int ramp_r;
  // Wired-AND: any party pulling wins, a released pin rises on its pull-up
  assign pin_n_o = ~(dut_oe_i | peer_pull_i);
  // Ramp before power-good; it falls on the next clock edge after the supply is disabled
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ramp_r <= 0;
    end else if (!supply_enable_i || hang_i) begin
      ramp_r <= 0;
    end else if (ramp_r < PG_CYCLES) begin
      ramp_r <= ramp_r + 1;
    end
  end
  assign power_good_o = (ramp_r == PG_CYCLES);
endmodule

// File: tb/supply_fault_response_test.sv
// Purpose: Self-checking bench of one fault response channel
// Assumes: Short millisecond tick (4 cycles) so filters and delays stay brief
// Notes: Each scenario restarts the channel from reset to drop any latched state
`timescale 1ns/1ps
`include "sfr_map.svh"
module supply_fault_response_test;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [5:0] sel = 6'h20;
  logic [4:0] tfault = 5'h00;
  logic [4:0] tsens = 5'h01;
  logic ovx = 1'b0, ocx = 1'b0, uvx = 1'b0, seq_on = 1'b0, poff = 1'b0, clr = 1'b0, hang = 1'b0;
  logic aen = 1'b1;
  logic offsel = 1'b0;
  logic [15:0] dly = 16'h0002;
  logic [1:0] worst = 2'h0;
  logic [2:0] union_drv = 3'h0, peer = 3'h0;
  logic [2:0] pin_n, pin_oe, pin_lvl;
  logic pg, supply, alert, logreq, alarm;
  logic [4:0] status, logtype, last_type;
  int err_total = 0, total_checks = 0, log_cnt = 0, alert_cnt = 0, cycles = 0;

  supply_fault_response #(.CHANNEL_ID(0), .TICK_CYCLES(TICK)) dut (
    .clk_i(clk), .reset_i(reset), .cmd_addr_i(addr), .cmd_wr_i(wr), .cmd_wdata_i(wdata),
    .cmd_rdata_o(rdata), .channel_function_setup_i(sel), .temp_fault_i(tfault),
    .temp_sensor_setup_i(tsens), .ov_excursion_i(ovx), .oc_excursion_i(ocx), .uv_excursion_i(uvx),
    .above_pgon_i(pg), .power_good_i(pg), .sequence_on_i(seq_on), .power_off_i(poff),
    .clear_faults_i(clr), .alert_enable_i(aen), .off_delay_select_i(offsel), .turn_off_delay_i(dly),
    .retry_delay_setting_i(dly), .power_up_time_limit_i(dly), .global_ot_worst_i(worst),
    .global_drive_union_i(union_drv), .shared_fault_pin_n_i(pin_n), .shared_fault_pin_n_o(pin_lvl),
    .shared_fault_pin_oe_o(pin_oe), .supply_enable_out_o(supply), .status_o(status),
    .alert_o(alert), .log_req_o(logreq), .log_type_o(logtype), .alarm_o(alarm));

  supply_peer_model far (
    .clk_i(clk), .reset_i(reset), .supply_enable_i(supply), .hang_i(hang),
    .dut_oe_i(pin_oe), .peer_pull_i(peer), .pin_n_o(pin_n), .power_good_o(pg));

  // Clock at 40 MHz
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Pulse counters and hang guard; counters clear with reset
  always @(posedge clk) begin
    cycles++;
    if (reset) begin
      log_cnt = 0;
      alert_cnt = 0;
      last_type = 5'h00;
    end else begin
      // Keep the type of the latest log request, it stands one cycle only
      if (logreq === 1'b1) begin
        last_type = logtype;
      end
      log_cnt += (logreq === 1'b1);
      alert_cnt += (alert === 1'b1);
    end
    if (cycles == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always change 2 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wr = 1'b1;
    wdata = d;
    step(1);
    wr = 1'b0;
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] fol, input logic [2:0] drv, input logic nv,
      input logic gl, input logic [1:0] flt, input logic [1:0] ot, input logic [1:0] ton,
      input logic [1:0] uv, input logic [1:0] ovc);
    return {5'h00, fol, 5'h00, drv, nv, gl, flt, 4'h0, ot, ton, uv, ovc};
  endfunction

  task automatic restart(input logic [5:0] s, input logic [31:0] c);
    {ovx, ocx, uvx, seq_on, poff, clr, hang} = 7'h00;
    tfault = 5'h00;
    tsens = 5'h01;
    peer = 3'h0;
    worst = 2'h0;
    union_drv = 3'h0;
    sel = s;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(1);
    write(`SFR_CFG_ADDR, c);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_register();
    restart(6'h20, 32'hFFFF_FFFF);
    check(rdata, 32'h0707_F7FF);
    step(1);
    write(8'hD8, 32'h0000_0000);
    check(rdata, 32'h0707_F7FF);
  endtask

  task automatic t_follow();
    restart(6'h20, cfg(3'h2, 3'h0, 1'b0, 1'b1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    seq_on = 1'b1;
    step(4);
    check(supply, 1'b1);
    peer = 3'h5;
    step(3);
    check(supply, 1'b1);
    peer = 3'h2;
    step(2);
    check(supply, 1'b0);
    step(10);
    check(supply, 1'b0);
    peer = 3'h0;
    step(5);
    check(supply, 1'b1);
    write(`SFR_CFG_ADDR, cfg(3'h2, 3'h0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    peer = 3'h2;
    step(3);
    check(supply, 1'b1);
  endtask

  task automatic t_local_ot();
    restart(6'h20, cfg(3'h0, 3'h0, 1'b1, 1'b0, 2'h0, 2'b01, 2'h0, 2'h0, 2'h0));
    tsens = 5'h04;
    seq_on = 1'b1;
    step(4);
    tfault = 5'h08;
    step(4);
    check(status, 5'h00);
    tfault = 5'h0C;
    step(4);
    check(status, 5'h10);
    check(supply, 1'b0);
    check(alert_cnt, 1);
    check(log_cnt, 1);
    check(last_type, 5'h10);
    tfault = 5'h00;
    step(20);
    check(supply, 1'b0);
    poff = 1'b1;
    step(2);
    poff = 1'b0;
    step(6);
    check(supply, 1'b1);
  endtask

  task automatic t_global_ot();
    restart(6'h20, cfg(3'h1, 3'h1, 1'b0, 1'b1, 2'h0, 2'b00, 2'h0, 2'h0, 2'h0));
    union_drv = 3'h5;
    worst = 2'b10;
    seq_on = 1'b1;
    step(4);
    tfault = 5'h01;
    step(5);
    check(pin_oe, 3'h5);
    check(supply, 1'b0);
    step(40);
    check(pin_oe, 3'h5);
    tfault = 5'h00;
    step(30);
    check(pin_oe, 3'h0);
    check(supply, 1'b1);
    worst = 2'b01;
    tfault = 5'h01;
    step(5);
    tfault = 5'h00;
    step(30);
    check(pin_oe, 3'h5);
    check(pin_lvl, 3'h0);
  endtask

  task automatic t_log_once();
    restart(6'h20, cfg(3'h0, 3'h0, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0, 2'b00, 2'b11));
    uvx = 1'b1;
    step(4);
    check(status, 5'h00);
    seq_on = 1'b1;
    step(8);
    check(status, 5'h04);
    check(log_cnt, 0);
    repeat (2) begin
      ovx = 1'b1;
      step(3);
      ovx = 1'b0;
      step(2);
    end
    check(log_cnt, 1);
    check(last_type, 5'h01);
    check(status, 5'h05);
    uvx = 1'b0;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    ovx = 1'b1;
    step(3);
    check(log_cnt, 2);
  endtask

  task automatic t_filter();
    for (int f = 1; f < 4; f++) begin
      restart(6'h20, cfg(3'h0, 3'h0, 1'b0, 1'b0, f[1:0], 2'b11, 2'h0, 2'h0, 2'b11));
      ovx = 1'b1;
      step((f + 1) * TICK - 2);
      check(status, 5'h00);
      step(2 * TICK + 6);
      check(status, 5'h01);
    end
    tfault = 5'h01;
    step(3);
    check(status, 5'h11);
  endtask

  task automatic t_timeout();
    restart(6'h10, cfg(3'h0, 3'h0, 1'b0, 1'b0, 2'h0, 2'h0, 2'b11, 2'h0, 2'h0) | 32'h0000_0100);
    hang = 1'b1;
    seq_on = 1'b1;
    step(4 * TICK + 6);
    check(status, 5'h08);
    check(alarm, 1'b1);
    seq_on = 1'b0;
    step(4);
    check(alarm, 1'b1);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(3);
    check(alarm, 1'b0);
    restart(6'h20, cfg(3'h0, 3'h0, 1'b0, 1'b0, 2'h0, 2'h0, 2'b11, 2'h0, 2'h0));
    hang = 1'b1;
    seq_on = 1'b1;
    step(4 * TICK + 6);
    check(status, 5'h00);
  endtask

  task automatic t_current();
    restart(6'h22, cfg(3'h0, 3'h0, 1'b0, 1'b1, 2'h0, 2'h0, 2'b11, 2'b11, 2'b11));
    seq_on = 1'b1;
    hang = 1'b1;
    ovx = 1'b1;
    uvx = 1'b1;
    step(4 * TICK + 6);
    check(status, 5'h00);
    ocx = 1'b1;
    step(3);
    check(status, 5'h02);
  endtask

  // Main sequence
  initial begin
    step(16);
    reset = 1'b0;
    step(1);
    check(rdata, 32'h0000_0000);
    t_register();
    t_follow();
    t_local_ot();
    t_global_ot();
    t_log_once();
    t_filter();
    t_timeout();
    t_current();
    report_and_stop();
  end
endmodule
